// ==== logic/ssr_defs.vh ====
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH
// Register byte addresses.
`define SSR_A_CTRL1 8'h00
`define SSR_A_DATA 8'h04
`define SSR_A_CTRL2 8'h08
`define SSR_A_SADR 8'h0c
`define SSR_A_SRST 8'h10
// Field positions.
`define SSR_F_BITCNT 7:5
`define SSR_B_ACKMODE 4
`define SSR_F_SADR 7:1
`define SSR_F_CMD 7:4
`define SSR_B_DIR 6
`define SSR_B_REL 4
`define SSR_B_SRST 0
// Commands in the top nibble of control_two.
`define SSR_CMD_START 4'hf
`define SSR_CMD_STOP 4'hd
`define SSR_CMD_RESTART 4'h1
// Word lengths, special addresses and line levels.
`define SSR_BITCNT_FULL 3'h0
`define SSR_NBITS_FULL 4'h8
`define SSR_ADDR_LAST 4'h7
`define SSR_GC_ADDR 7'h00
`define SSR_LINE_IDLE 1'b1
// Reset values.
`define SSR_RST_BITCNT 3'h0
`define SSR_RST_BYTE 8'h00
`define SSR_RST_SADR 7'h00
`define SSR_RST_CNT 4'h0
`define SSR_RST_DIV 10'h000
// Timing: half of a standard-mode clock period.
`define SSR_CLK_MHZ 100
`define SSR_HALF_NS 5000
`define SSR_HALF_CYC ((`SSR_HALF_NS * `SSR_CLK_MHZ + 999) / 1000)
`endif

// ==== logic/ssr_sync.v ====
`default_nettype none
`include "ssr_defs.vh"
module ssr_sync (
    input wire ref_clk, // System clock.
    input wire sys_rst, // Synchronous reset, active high.
    input wire ce, // Clock enable.
    input wire [1:0] din, // Asynchronous line levels.
    output wire [1:0] dout // Synchronised line levels.
);

genvar i;
generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
        reg s1_reg;
        reg s2_reg;
        always @(posedge ref_clk) begin
            if (sys_rst) begin
                s1_reg <= `SSR_LINE_IDLE;
                s2_reg <= `SSR_LINE_IDLE;
            end else if (ce) begin
                s1_reg <= din[i];
                s2_reg <= s1_reg;
            end
        end
        assign dout[i] = s2_reg;
    end
endgenerate

endmodule // ssr_sync
`default_nettype wire

// ==== logic/ssr_edge.v ====
`default_nettype none
`include "ssr_defs.vh"
module ssr_edge (
    input wire ref_clk, // System clock.
    input wire sys_rst, // Synchronous reset, active high.
    input wire ce, // Clock enable.
    input wire scl, // Synchronised clock line.
    input wire sda, // Synchronised data line.
    output wire scl_rise, // Clock line rose.
    output wire scl_fall, // Clock line fell.
    output wire start_det, // Data fell while clock high.
    output wire stop_det // Data rose while clock high.
);

reg scl_p_reg;
reg sda_p_reg;

always @(posedge ref_clk) begin
    if (sys_rst) begin
        scl_p_reg <= `SSR_LINE_IDLE;
        sda_p_reg <= `SSR_LINE_IDLE;
    end else if (ce) begin
        scl_p_reg <= scl;
        sda_p_reg <= sda;
    end
end

assign scl_rise = ce & scl & ~scl_p_reg;
assign scl_fall = ce & ~scl & scl_p_reg;
assign start_det = ce & scl & scl_p_reg & sda_p_reg & ~sda;
assign stop_det = ce & scl & scl_p_reg & ~sda_p_reg & sda;

endmodule // ssr_edge
`default_nettype wire

// ==== logic/ssr_top.v ====
`default_nettype none
`include "ssr_defs.vh"
module ssr_top (
    input wire ref_clk, // System clock, 100 MHz.
    input wire sys_rst, // Synchronous reset, active high.
    input wire ce, // Clock enable, freezes all state.
    input wire [7:0] reg_addr, // Register byte address.
    input wire [7:0] reg_wdata, // Register write data.
    input wire reg_wr, // Write strobe.
    input wire reg_rd, // Read strobe.
    output wire [7:0] reg_rdata, // Read data, cycle after the strobe.
    output wire transfer_irq, // One-cycle pulse at word end.
    input wire clock_line_pad_in, // Clock line level.
    output wire clock_line_pad_out, // Clock drive value, low.
    output wire clock_line_pad_oe, // High while pulling clock low.
    input wire data_line_pad_in, // Data line level.
    output wire data_line_pad_out, // Data drive value, low.
    output wire data_line_pad_oe // High while pulling data low.
);

localparam [2:0] M_IDLE = 3'h0;
localparam [2:0] M_START = 3'h1;
localparam [2:0] M_LOW = 3'h2;
localparam [2:0] M_HIGH = 3'h3;
localparam [2:0] M_STOPA = 3'h4;
localparam [2:0] M_STOPB = 3'h5;
localparam [2:0] M_RREL = 3'h6;
localparam integer HALF_I = `SSR_HALF_CYC;
localparam [9:0] HALF_M1 = HALF_I[9:0] - 10'h001;

reg [7:0] rdata_reg;
reg irq_reg;
reg scl_oe_reg;
reg sda_oe_reg;
reg pad_out_reg;
reg [2:0] bit_count_reg;
reg ack_mode_reg;
reg [6:0] sadr_reg;
reg [7:0] tx_reg;
reg [7:0] rx_reg;
reg [7:0] sh_reg;
reg master_select_reg;
reg transmit_dir_reg;
reg bus_busy_reg;
reg service_release_reg;
reg arb_lost_reg;
reg addressed_reg;
reg general_call_reg;
reg last_rx_bit_reg;
reg restart_reg;
reg active_reg;
reg adr_ph_reg;
reg done_reg;
reg hit_reg;
reg gcm_reg;
reg slave_hit_reg;
reg [3:0] cnt_reg;
reg [2:0] mst_reg;
reg [9:0] div_reg;

wire [1:0] line_s;
wire scl_s;
wire sda_s;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;

ssr_sync u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din({clock_line_pad_in, data_line_pad_in}),
    .dout(line_s)
);

assign scl_s = line_s[1];
assign sda_s = line_s[0];

ssr_edge u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .scl(scl_s),
    .sda(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
);

wire wr_c1 = reg_wr & (reg_addr == `SSR_A_CTRL1);
wire wr_dat = reg_wr & (reg_addr == `SSR_A_DATA);
wire rd_dat = reg_rd & (reg_addr == `SSR_A_DATA);
wire wr_c2 = reg_wr & (reg_addr == `SSR_A_CTRL2);
wire wr_sa = reg_wr & (reg_addr == `SSR_A_SADR);
wire soft_rst = reg_wr & (reg_addr == `SSR_A_SRST) & reg_wdata[`SSR_B_SRST];
wire [3:0] cmd = reg_wdata[`SSR_F_CMD];
wire cmd_start = wr_c2 & (cmd == `SSR_CMD_START) & ~bus_busy_reg;
wire cmd_stop = wr_c2 & (cmd == `SSR_CMD_STOP) & bus_busy_reg;
wire cmd_rs = wr_c2 & (cmd == `SSR_CMD_RESTART) & master_select_reg;
wire rel_c2 = wr_c2 & reg_wdata[`SSR_B_REL] & ~cmd_stop & ~cmd_rs;
wire rel_go = ~service_release_reg & ~cmd_start &
    (wr_dat | rd_dat | rel_c2);
wire [7:0] rel_sh = wr_dat ? reg_wdata : tx_reg;
wire rel_dir = wr_c2 ? reg_wdata[`SSR_B_DIR] : transmit_dir_reg;
wire [3:0] nbits = (adr_ph_reg | bit_count_reg == `SSR_BITCNT_FULL) ?
    `SSR_NBITS_FULL : {1'b0, bit_count_reg};
wire ack_en = adr_ph_reg | ack_mode_reg;
wire [3:0] last_bit = ack_en ? nbits : nbits - 4'h1;
wire in_data = cnt_reg < nbits;
wire talker = master_select_reg | slave_hit_reg;
wire arb_now = active_reg & scl_rise & ~done_reg & in_data &
    master_select_reg & transmit_dir_reg & sh_reg[7] & ~sda_s;
wire [7:0] adr_byte = {sh_reg[6:0], sda_s};
wire adr_gc = adr_byte[7:1] == `SSR_GC_ADDR;
wire adr_hit = (adr_byte[7:1] == sadr_reg) | adr_gc;
wire half_done = div_reg == HALF_M1;
wire m_scl_low = (mst_reg == M_LOW) | (mst_reg == M_STOPA);
wire [7:0] status = {master_select_reg, transmit_dir_reg, bus_busy_reg,
    service_release_reg, arb_lost_reg, addressed_reg, general_call_reg,
    last_rx_bit_reg};

assign reg_rdata = rdata_reg;
assign transfer_irq = irq_reg;
assign clock_line_pad_out = pad_out_reg;
assign clock_line_pad_oe = scl_oe_reg;
assign data_line_pad_out = pad_out_reg;
assign data_line_pad_oe = sda_oe_reg;

// Configuration survives the software reset.
always @(posedge ref_clk) begin
    if (sys_rst) begin
        bit_count_reg <= `SSR_RST_BITCNT;
        ack_mode_reg <= 1'b0;
        sadr_reg <= `SSR_RST_SADR;
        tx_reg <= `SSR_RST_BYTE;
    end else if (ce) begin
        if (wr_c1) begin
            bit_count_reg <= reg_wdata[`SSR_F_BITCNT];
            ack_mode_reg <= reg_wdata[`SSR_B_ACKMODE];
        end
        if (wr_sa) begin
            sadr_reg <= reg_wdata[`SSR_F_SADR];
        end
        if (wr_dat) begin
            tx_reg <= reg_wdata;
        end
    end
end

always @(posedge ref_clk) begin
    if (sys_rst) begin
        rdata_reg <= `SSR_RST_BYTE;
    end else if (ce) begin
        rdata_reg <= `SSR_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `SSR_A_CTRL1: begin
                    rdata_reg <= {bit_count_reg, ack_mode_reg, 4'h0};
                end
                `SSR_A_DATA: begin
                    rdata_reg <= rx_reg;
                end
                `SSR_A_CTRL2: begin
                    rdata_reg <= status;
                end
                `SSR_A_SADR: begin
                    rdata_reg <= {sadr_reg, 1'b0};
                end
                default: begin
                    rdata_reg <= `SSR_RST_BYTE;
                end
            endcase
        end
    end
end

always @(posedge ref_clk) begin
    if (sys_rst | (ce & soft_rst)) begin
        irq_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        pad_out_reg <= 1'b0;
        rx_reg <= `SSR_RST_BYTE;
        sh_reg <= `SSR_RST_BYTE;
        master_select_reg <= 1'b0;
        transmit_dir_reg <= 1'b0;
        bus_busy_reg <= 1'b0;
        service_release_reg <= 1'b1;
        arb_lost_reg <= 1'b0;
        addressed_reg <= 1'b0;
        general_call_reg <= 1'b0;
        last_rx_bit_reg <= 1'b0;
        restart_reg <= 1'b0;
        active_reg <= 1'b0;
        adr_ph_reg <= 1'b0;
        done_reg <= 1'b0;
        hit_reg <= 1'b0;
        gcm_reg <= 1'b0;
        slave_hit_reg <= 1'b0;
        cnt_reg <= `SSR_RST_CNT;
        mst_reg <= M_IDLE;
        div_reg <= `SSR_RST_DIV;
    end else if (ce) begin
        irq_reg <= 1'b0;
        // Clock is pulled low by the master phases or a pending word.
        scl_oe_reg <= m_scl_low | (active_reg & ~service_release_reg);
        case (mst_reg)
            M_IDLE: begin
                div_reg <= `SSR_RST_DIV;
            end
            M_START: begin
                sda_oe_reg <= 1'b1;
                div_reg <= div_reg + 10'h001;
                if (half_done) begin
                    mst_reg <= M_LOW;
                    div_reg <= `SSR_RST_DIV;
                end
            end
            M_LOW: begin
                if (!half_done) begin
                    div_reg <= div_reg + 10'h001;
                end else if (service_release_reg) begin
                    mst_reg <= M_HIGH;
                    div_reg <= `SSR_RST_DIV;
                end
            end
            M_HIGH: begin
                div_reg <= div_reg + 10'h001;
                if (!scl_s) begin
                    div_reg <= `SSR_RST_DIV;
                end else if (half_done) begin
                    mst_reg <= M_LOW;
                    div_reg <= `SSR_RST_DIV;
                end
            end
            M_STOPA: begin
                sda_oe_reg <= 1'b1;
                div_reg <= div_reg + 10'h001;
                if (half_done) begin
                    mst_reg <= M_STOPB;
                    div_reg <= `SSR_RST_DIV;
                end
            end
            M_STOPB: begin
                // Held data low until the clock has been seen high for half a period.
                div_reg <= div_reg + 10'h001;
                if (!scl_s) begin
                    div_reg <= `SSR_RST_DIV;
                end else if (half_done) begin
                    sda_oe_reg <= 1'b0;
                    mst_reg <= M_IDLE;
                end
            end
            M_RREL: begin
                sda_oe_reg <= 1'b0;
                if (scl_s) begin
                    bus_busy_reg <= 1'b0;
                    restart_reg <= 1'b1;
                    mst_reg <= M_IDLE;
                end
            end
            default: begin
                mst_reg <= M_IDLE;
            end
        endcase
        if (active_reg & scl_rise & ~done_reg) begin
            if (in_data) begin
                sh_reg <= adr_byte;
            end
            if (arb_now) begin
                arb_lost_reg <= 1'b1;
                master_select_reg <= 1'b0;
                transmit_dir_reg <= 1'b0;
                mst_reg <= M_IDLE;
                sda_oe_reg <= 1'b0;
            end
            if (adr_ph_reg & (cnt_reg == `SSR_ADDR_LAST) &
                (~master_select_reg | arb_now)) begin
                hit_reg <= adr_hit;
                gcm_reg <= adr_gc;
            end
            if (cnt_reg == last_bit) begin
                done_reg <= 1'b1;
                last_rx_bit_reg <= sda_s;
                if (adr_ph_reg & master_select_reg & ~sda_s) begin
                    transmit_dir_reg <= ~sh_reg[0];
                end
                if (adr_ph_reg & ~master_select_reg & hit_reg) begin
                    addressed_reg <= 1'b1;
                    slave_hit_reg <= 1'b1;
                    general_call_reg <= gcm_reg;
                    transmit_dir_reg <= ~gcm_reg & sh_reg[0];
                end
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
        if (active_reg & scl_fall) begin
            if (done_reg) begin
                // Word end: report and stretch the clock.
                done_reg <= 1'b0;
                service_release_reg <= 1'b0;
                irq_reg <= 1'b1;
                rx_reg <= sh_reg;
                adr_ph_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
            end else if (in_data) begin
                sda_oe_reg <= transmit_dir_reg & talker & ~sh_reg[7];
            end else if (adr_ph_reg) begin
                sda_oe_reg <= ~master_select_reg & hit_reg;
                if (~master_select_reg & ~hit_reg & ~arb_lost_reg) begin
                    active_reg <= 1'b0;
                end
            end else begin
                sda_oe_reg <= ~transmit_dir_reg & talker;
            end
        end
        if (rel_go) begin
            service_release_reg <= 1'b1;
            cnt_reg <= `SSR_RST_CNT;
            done_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
            addressed_reg <= 1'b0;
            general_call_reg <= 1'b0;
            sh_reg <= rel_sh;
            transmit_dir_reg <= rel_dir;
            sda_oe_reg <= rel_dir & talker & ~rel_sh[7];
            if (arb_lost_reg & ~slave_hit_reg) begin
                active_reg <= 1'b0;
            end
        end
        if (restart_reg) begin
            last_rx_bit_reg <= scl_s;
        end
        if (start_det) begin
            bus_busy_reg <= 1'b1;
            active_reg <= 1'b1;
            adr_ph_reg <= 1'b1;
            cnt_reg <= `SSR_RST_CNT;
            done_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
            addressed_reg <= 1'b0;
            general_call_reg <= 1'b0;
            slave_hit_reg <= 1'b0;
            hit_reg <= 1'b0;
            restart_reg <= 1'b0;
        end
        if (stop_det) begin
            bus_busy_reg <= 1'b0;
            active_reg <= 1'b0;
            master_select_reg <= 1'b0;
            transmit_dir_reg <= 1'b0;
            arb_lost_reg <= 1'b0;
            addressed_reg <= 1'b0;
            general_call_reg <= 1'b0;
            slave_hit_reg <= 1'b0;
            service_release_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            mst_reg <= M_IDLE;
        end
        if (cmd_start) begin
            master_select_reg <= 1'b1;
            transmit_dir_reg <= 1'b1;
            service_release_reg <= 1'b1;
            sh_reg <= tx_reg;
            restart_reg <= 1'b0;
            mst_reg <= M_START;
            div_reg <= `SSR_RST_DIV;
        end
        if (cmd_stop) begin
            service_release_reg <= 1'b1;
            active_reg <= 1'b0;
            mst_reg <= M_STOPA;
            div_reg <= `SSR_RST_DIV;
        end
        if (cmd_rs) begin
            // Bus is marked free once the clock is high, though no stop is sent.
            master_select_reg <= 1'b0;
            transmit_dir_reg <= 1'b0;
            service_release_reg <= 1'b1;
            active_reg <= 1'b0;
            mst_reg <= M_RREL;
        end
    end
end

endmodule // ssr_top
`default_nettype wire

// ==== verif/ssr_assertions.sv ====
`default_nettype none
`include "ssr_defs.vh"
module ssr_assertions (
    input wire logic ref_clk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic [7:0] reg_addr, // Address.
    input wire logic [7:0] reg_wdata, // Write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    input wire logic [7:0] reg_rdata, // Read data.
    input wire logic transfer_irq, // Word end.
    input wire logic clock_line_pad_out, // Clock drive.
    input wire logic clock_line_pad_oe, // Clock pull.
    input wire logic data_line_pad_out, // Data drive.
    input wire logic data_line_pad_oe // Data pull.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire logic wr2;
    wire logic idle;
    assign wr2 = reg_wr && reg_addr == `SSR_A_CTRL2;
    assign idle = !clock_line_pad_oe && !data_line_pad_oe;
    property p_rst_idle;
        disable iff (1'b0) sys_rst |=> !transfer_irq && idle
            && reg_rdata == 8'h00;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs not idle in reset");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read strobe");
    property p_irq_pulse;
        transfer_irq |=> !transfer_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");
    property p_irq_hold;
        transfer_irq |-> ##8 clock_line_pad_oe [*4];
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("clock not held low after interrupt");
    property p_release;
        reg_rd && reg_addr == `SSR_A_DATA && clock_line_pad_oe
            |-> ##[1:600] !clock_line_pad_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("data read did not free the clock");
    property p_srst;
        reg_wr && reg_addr == `SSR_A_SRST && reg_wdata[0]
            |-> ##[1:4] idle [*8];
    endproperty
    a_srst: assert property (p_srst)
        else $error("soft reset left a line driven");
    // The restart code is written both with and without master_select set.
    property p_restart;
        wr2 && reg_wdata[7:4] == `SSR_CMD_RESTART |-> ##[1:600] idle [*8];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart release did not free both lines");
    property p_pad_low;
        !clock_line_pad_out && !data_line_pad_out;
    endproperty
    a_pad_low: assert property (p_pad_low)
        else $error("open drain output drives high");
    c_irq: cover property (transfer_irq);
    c_stop: cover property (wr2 && reg_wdata[7:4] == `SSR_CMD_STOP);
    c_rst: cover property (wr2 && reg_wdata[7:4] == `SSR_CMD_RESTART);
endmodule // ssr_assertions
bind ssr_top ssr_assertions chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .transfer_irq(transfer_irq),
    .clock_line_pad_out(clock_line_pad_out),
    .clock_line_pad_oe(clock_line_pad_oe),
    .data_line_pad_out(data_line_pad_out),
    .data_line_pad_oe(data_line_pad_oe)
);
`default_nettype wire

// ==== verif/ssr_bus_model.sv ====
`default_nettype none
module ssr_bus_model (
    input wire logic scl_w, // Clock line level.
    input wire logic sda_w, // Data line level.
    output var logic scl_pull, // Pulls clock low.
    output var logic sda_pull // Pulls data low.
);
    timeunit 1ns;
    timeprecision 1ps;
    int stops = 0;
    int hangs = 0;
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    always @(posedge sda_w) if (scl_w === 1'b1) stops++;
    task automatic wait_scl(input logic v);
        int i;
        for (i = 0; i < 20000 && scl_w !== v; i++) #10;
        if (scl_w !== v) hangs++;
    endtask
    // Releasing the clock waits while anyone else stretches it.
    task automatic clk_bit(input logic o, output logic i);
        #10 sda_pull = !o;
        #30;
        scl_pull = 1'b0;
        wait_scl(1'b1);
        #40;
        i = sda_w;
        scl_pull = 1'b1;
    endtask
    task automatic start_c();
        sda_pull = 1'b1;
        #40;
        scl_pull = 1'b1;
    endtask
    task automatic stop_c();
        logic x;
        clk_bit(1'b0, x);
        scl_pull = 1'b0;
        #40;
        sda_pull = 1'b0;
        #40;
    endtask
    // Nine clocks, MSB first; bit 0 is the acknowledge slot.
    task automatic xfer(input logic [8:0] o, output logic [8:0] i);
        int k;
        for (k = 8; k >= 0; k--) clk_bit(o[k], i[k]);
    endtask
    task automatic slv(output logic [7:0] b);
        int k;
        wait_scl(1'b0);
        for (k = 7; k >= 0; k--) begin
            wait_scl(1'b1);
            b[k] = sda_w;
            wait_scl(1'b0);
        end
        #10 sda_pull = 1'b1;
        wait_scl(1'b1);
        wait_scl(1'b0);
        #10 sda_pull = 1'b0;
    endtask
endmodule // ssr_bus_model
`default_nettype wire

// ==== verif/test_ssr_top.sv ====
`default_nettype none
`include "ssr_defs.vh"
module test_ssr_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [7:0] reg_rdata;
    wire logic transfer_irq, c_oe, d_oe, scl_pull, sda_pull;
    wire logic scl_w = !(c_oe || scl_pull);
    wire logic sda_w = !(d_oe || sda_pull);
    int failures = 0;
    int n_checks = 0;
    int irqs = 0;
    int n_irq = 0;
    int s0;
    int k;
    logic [8:0] r;
    logic [7:0] d;
    ssr_top dut_u (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transfer_irq(transfer_irq),
        .clock_line_pad_in(scl_w), .clock_line_pad_out(),
        .clock_line_pad_oe(c_oe), .data_line_pad_in(sda_w),
        .data_line_pad_out(), .data_line_pad_oe(d_oe)
    );
    ssr_bus_model bm (
        .scl_w(scl_w), .sda_w(sda_w), .scl_pull(scl_pull),
        .sda_pull(sda_pull)
    );
    always #5 ref_clk = !ref_clk;
    always @(posedge ref_clk) if (transfer_irq === 1'b1) irqs++;
    task automatic stop_test(input logic hung);
        if (hung) failures++;
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge ref_clk);
    endtask
    task automatic rchk(input logic [7:0] a, m, e);
        rd(a, d);
        chk(d & m, e);
    endtask
    task automatic poll(input logic [7:0] m, e);
        int i;
        // Always read afresh: a stale status byte must not end the wait.
        rd(`SSR_A_CTRL2, d);
        for (i = 0; i < 1000 && (d & m) !== e; i++) rd(`SSR_A_CTRL2, d);
        if ((d & m) !== e) stop_test(1'b1);
    endtask
    task automatic wait_irq();
        int i;
        n_irq++;
        for (i = 0; i < 20000 && irqs < n_irq; i++) @(posedge ref_clk);
        if (irqs < n_irq) stop_test(1'b1);
        repeat (12) @(posedge ref_clk);
    endtask
    task automatic mstart(input logic [7:0] b);
        logic [7:0] got;
        fork
            bm.slv(got);
            begin
                wr(`SSR_A_DATA, b);
                wr(`SSR_A_CTRL2, 8'hf0);
            end
        join
        chk(got, b);
        wait_irq();
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rchk(`SSR_A_CTRL2, 8'hff, 8'h10);
        rchk(8'h14, 8'hff, 8'h00);
        wr(`SSR_A_SADR, 8'hb4);
        wr(`SSR_A_CTRL1, 8'h10);
        for (k = 0; k < 2; k++) begin
            bm.start_c();
            bm.xfer({k ? 8'h00 : 8'hb4, 1'b1}, r);
            chk({7'h00, r[0]}, 8'h00);
            wait_irq();
            rchk(`SSR_A_CTRL2, 8'hfe, k ? 8'h26 : 8'h24);
            rd(`SSR_A_DATA, d);
            rchk(`SSR_A_CTRL2, 8'h10, 8'h10);
            bm.xfer({8'h3c, 1'b1}, r);
            wait_irq();
            rd(`SSR_A_DATA, d);
            chk(d, 8'h3c);
            bm.stop_c();
            @(posedge ref_clk);
            rchk(`SSR_A_CTRL2, 8'h2e, 8'h00);
        end
        bm.start_c();
        bm.xfer({8'hb5, 1'b1}, r);
        wait_irq();
        rchk(`SSR_A_CTRL2, 8'hfe, 8'h64);
        wr(`SSR_A_CTRL1, 8'h10);
        wr(`SSR_A_DATA, 8'ha5);
        bm.xfer({8'hff, 1'b1}, r);
        chk(r[8:1], 8'ha5);
        wait_irq();
        rchk(`SSR_A_CTRL2, 8'hff, 8'h61);
        wr(`SSR_A_CTRL2, 8'h10);
        bm.stop_c();
        @(posedge ref_clk);
        mstart(8'hb4);
        rchk(`SSR_A_CTRL2, 8'hfe, 8'he0);
        // Another device stretches the clock before the stop command.
        bm.scl_pull = 1'b1;
        s0 = bm.stops;
        wr(`SSR_A_CTRL2, 8'hd0);
        repeat (1200) @(posedge ref_clk);
        chk({7'h00, sda_w}, 8'h00);
        chk(8'(bm.stops - s0), 8'h00);
        bm.scl_pull = 1'b0;
        for (k = 0; k < 3000 && bm.stops == s0; k++) @(posedge ref_clk);
        // The stop reaches the status only after the line synchronisers.
        repeat (4) @(posedge ref_clk);
        chk(8'(bm.stops - s0), 8'h01);
        rchk(`SSR_A_CTRL2, 8'he0, 8'h00);
        mstart(8'hb4);
        s0 = bm.stops;
        wr(`SSR_A_CTRL2, 8'h10);
        poll(8'h20, 8'h00);
        chk({6'h00, scl_w, sda_w}, 8'h03);
        poll(8'h01, 8'h01);
        repeat (470) @(posedge ref_clk);
        chk(8'(bm.stops - s0), 8'h00);
        mstart(8'hb5);
        wr(`SSR_A_SRST, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk({6'h00, scl_w, sda_w}, 8'h03);
        rchk(`SSR_A_CTRL2, 8'hff, 8'h10);
        rchk(`SSR_A_CTRL1, 8'hff, 8'h10);
        bm.stop_c();
        chk(8'(bm.hangs), 8'h00);
        stop_test(1'b0);
    end
endmodule // test_ssr_top
`default_nettype wire
